/* common/slice_pkg.sv */
/*
  Shared constants and types for the configurable logic slice.
  Assumes a single clock domain and a synchronous active-high reset.
*/
package slice_pkg;

  // ************************************************************
  // Modes and sub-functions
  // ************************************************************
  typedef enum logic [1:0] {
    MODE_LOGIC,
    MODE_RIPPLE,
    MODE_RAM,
    MODE_ROM
  } slice_mode_type;

  typedef enum logic [2:0] {
    RIP_ADD,
    RIP_SUB,
    RIP_ADDSUB,
    RIP_UPCNT,
    RIP_DNCNT,
    RIP_UDCNT_CLR,
    RIP_UDCNT_LOAD,
    RIP_MULT
  } ripple_func_type;

  // ************************************************************
  // Widths and sizes
  // ************************************************************
  localparam int TABLE_INPUTS   = 4;
  localparam int TABLE_ENTRIES  = 16;
  localparam int ARITH_WIDTH    = 2;
  localparam int RAM_WORDS      = 16;
  localparam int RAM_WIDTH      = 4;
  localparam int RAM_ADDR_WIDTH = 4;
  localparam int CHAIN_SLICES   = 5;
  localparam int CHAIN_INPUTS   = 8;
  localparam int SEL_WIDTH      = 3;

  // Reset values and count step
  localparam logic [TABLE_ENTRIES-1:0] TABLE_RESET = 16'h0000;
  localparam logic [ARITH_WIDTH-1:0]   COUNT_ZERO  = 2'h0;
  localparam logic [ARITH_WIDTH-1:0]   COUNT_ONE   = 2'h1;

endpackage

/* hw/storage_column.sv */
/*
  One 16-entry by 1-bit storage column, the table of a slice reused as RAM.
  Assumes the config port writes initial contents before user operation.
*/
`timescale 1ns/1ps
`default_nettype none
module storage_column
  import slice_pkg::*;
(
  input  wire logic                      clk_i,
  input  wire logic                      cfg_we_i,
  input  wire logic [TABLE_ENTRIES-1:0]  cfg_data_i,
  input  wire logic                      we_i,
  input  wire logic [RAM_ADDR_WIDTH-1:0] waddr_i,
  input  wire logic                      wdata_i,
  input  wire logic [RAM_ADDR_WIDTH-1:0] raddr_i,
  output logic                           rdata_o,
  output logic [TABLE_ENTRIES-1:0]       contents_o
);

  // ************************************************************
  // Storage
  // ************************************************************
  logic [TABLE_ENTRIES-1:0] bits_r;
  logic [TABLE_ENTRIES-1:0] bits_nxt;

  // Contents survive reset, like real configuration memory
  always_comb begin
    bits_nxt = bits_r;
    if (cfg_we_i) begin
      bits_nxt = cfg_data_i;
    end else if (we_i) begin
      bits_nxt[waddr_i] = wdata_i;
    end
  end

  always_ff @(posedge clk_i) begin
    bits_r <= bits_nxt;
  end

  // Asynchronous read path
  assign rdata_o    = bits_r[raddr_i];
  assign contents_o = bits_r;

endmodule
`default_nettype wire

/* hw/logic_slice_modes.sv */
/*
  Configurable logic slice group: table logic, ripple arithmetic, RAM and ROM.
  Assumes configuration writes arrive on cfg_* before user operation and
  that user inputs come from fabric logic on the same clock.
*/
// Added by the designer: the register offsets and the plain strobed port.
// Operation
// - The slice runs in one of four modes: logic, ripple, RAM or ROM.
// - Each four-input table gives a programmed output for each of its 16 input codes.
// - Two four-input tables in a slice combine into one five-input function; the code takes the two tables from slices 0 and 1.
// - Chaining slices builds up to an eight-input table, which needs more than four slices.
// - Ripple mode adds, subtracts, or adds/subtracts under a dynamic control, two bits wide.
// - Ripple mode counts two bits up or down, and an up/down counter has an asynchronous clear.
// - An up/down counter variant loads a preload value synchronously.
// - Ripple mode flags A >= B, A != B and A <= B.
// - Ripple mode gives a multiplier building block chainable across slices.
// - Fast carry mode gives per-slice carry generate and propagate signals.
// - RAM mode forms a 16x4 single-port memory from four 16x1 storage columns.
// - A third slice supplies address and control to the storage slices.
// - Memory contents of columns 0 and 2 are loadable with initial values during configuration; columns 1 and 3 are not.
// - Each slice register comes up set or cleared as configured and holds it on entering user mode.
`timescale 1ns/1ps
`default_nettype none
module logic_slice_modes
  import slice_pkg::*;
(
  input  wire logic                        clk_i,
  input  wire logic                        reset_i,
  // Configuration
  input  wire logic                        cfg_we_i,
  input  wire logic [SEL_WIDTH-1:0]        cfg_sel_i,
  input  wire logic [TABLE_ENTRIES-1:0]    cfg_data_i,
  input  wire logic [1:0]                  cfg_mode_i,
  input  wire logic [2:0]                  cfg_func_i,
  input  wire logic                        cfg_fast_carry_i,
  input  wire logic [ARITH_WIDTH-1:0]      cfg_reg_init_i,
  input  wire logic                        cfg_done_i,
  // Logic mode inputs
  input  wire logic [TABLE_INPUTS-1:0]     table_in_i,
  input  wire logic                        table_sel5_i,
  input  wire logic [CHAIN_INPUTS-1:0]     chain_in_i,
  // Ripple mode inputs
  input  wire logic [ARITH_WIDTH-1:0]      op_a_i,
  input  wire logic [ARITH_WIDTH-1:0]      op_b_i,
  input  wire logic                        carry_i,
  input  wire logic                        add_nsub_i,
  input  wire logic                        count_en_i,
  input  wire logic                        count_up_i,
  input  wire logic                        count_clr_i,
  input  wire logic                        count_load_i,
  input  wire logic [ARITH_WIDTH-1:0]      preload_i,
  input  wire logic                        mult_bit_i,
  // RAM / ROM port
  input  wire logic [RAM_ADDR_WIDTH-1:0]   ram_addr_i,
  input  wire logic [RAM_WIDTH-1:0]        ram_wdata_i,
  input  wire logic                        ram_we_i,
  // Outputs
  output logic                             four_input_table_o,
  output logic                             five_input_table_o,
  output logic                             eight_input_table_o,
  output logic [ARITH_WIDTH-1:0]           sum_o,
  output logic                             carry_o,
  output logic                             carry_gen_o,
  output logic                             carry_prop_o,
  output logic [ARITH_WIDTH-1:0]           count_o,
  output logic                             a_ge_b_o,
  output logic                             a_ne_b_o,
  output logic                             a_le_b_o,
  output logic [RAM_WIDTH-1:0]             ram_rdata_o,
  output logic [1:0]                       mode_o
);

  // ************************************************************
  // Configuration state
  // ************************************************************
  slice_mode_type  mode_r, mode_nxt;
  ripple_func_type func_r, func_nxt;
  logic            fast_r, fast_nxt;
  logic [ARITH_WIDTH-1:0] init_r, init_nxt;

  // Mode and function latched only while configuring
  always_comb begin
    mode_nxt = mode_r;
    func_nxt = func_r;
    fast_nxt = fast_r;
    init_nxt = init_r;
    if (!cfg_done_i) begin
      mode_nxt = slice_mode_type'(cfg_mode_i);
      func_nxt = ripple_func_type'(cfg_func_i);
      fast_nxt = cfg_fast_carry_i;
      init_nxt = cfg_reg_init_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      mode_r <= MODE_LOGIC;
      func_r <= RIP_ADD;
      fast_r <= 1'b0;
      init_r <= COUNT_ZERO;
    end else begin
      mode_r <= mode_nxt;
      func_r <= func_nxt;
      fast_r <= fast_nxt;
      init_r <= init_nxt;
    end
  end

  assign mode_o = mode_r;

  // ************************************************************
  // Table storage: two tables plus chain slices
  // ************************************************************
  // Selects 0 and 1 reach the slice pair in the storage columns; chain slices follow
  localparam int PAIR_TABLES    = 2;
  localparam int COLS_PER_SLICE = 2;
  logic [TABLE_ENTRIES-1:0] chain_tbl_r   [CHAIN_SLICES];
  logic [TABLE_ENTRIES-1:0] chain_tbl_nxt [CHAIN_SLICES];

  genvar gi;
  generate
    for (gi = 0; gi < CHAIN_SLICES; gi++) begin : g_tbl
      // Configuration load only; contents not touched by reset
      always_comb begin
        chain_tbl_nxt[gi] = chain_tbl_r[gi];
        if (cfg_we_i && (cfg_sel_i == SEL_WIDTH'(gi + PAIR_TABLES))) begin
          chain_tbl_nxt[gi] = cfg_data_i;
        end
      end
      always_ff @(posedge clk_i) begin
        chain_tbl_r[gi] <= chain_tbl_nxt[gi];
      end
    end
  endgenerate

  // ************************************************************
  // Storage columns: tables of slices 0 and 1 double as RAM
  // ************************************************************
  logic [RAM_WIDTH-1:0]     col_rdata;
  logic [TABLE_ENTRIES-1:0] col_bits [RAM_WIDTH];
  logic                     ram_wr;

  // Address and control come from the control slice
  assign ram_wr = (mode_r == MODE_RAM) && ram_we_i && !cfg_we_i;

  generate
    for (gi = 0; gi < RAM_WIDTH; gi++) begin : g_col
      // Only the first column of each slice takes configuration data
      localparam logic [SEL_WIDTH-1:0] COL_SEL = SEL_WIDTH'(gi / COLS_PER_SLICE);
      localparam bit                   COL_CFG = ((gi % COLS_PER_SLICE) == 0);
      storage_column u_col (
        .clk_i      (clk_i),
        .cfg_we_i   (cfg_we_i && COL_CFG && (cfg_sel_i == COL_SEL)),
        .cfg_data_i (cfg_data_i),
        .we_i       (ram_wr),
        .waddr_i    (ram_addr_i),
        .wdata_i    (ram_wdata_i[gi]),
        .raddr_i    (ram_addr_i),
        .rdata_o    (col_rdata[gi]),
        .contents_o (col_bits[gi])
      );
    end
  endgenerate

  // Combinational read in RAM and ROM mode
  always_comb begin
    ram_rdata_o = {RAM_WIDTH{1'b0}};
    if (mode_r == MODE_RAM || mode_r == MODE_ROM) begin
      ram_rdata_o = col_rdata;
    end
  end

  // ************************************************************
  // Logic mode: four, five and eight input tables
  // ************************************************************
  logic t0, t1;
  logic [CHAIN_SLICES-1:0] chain_out;
  // Logic tables 0 and 1 are the even columns of the storage pair
  assign t0 = col_bits[0][table_in_i];
  assign t1 = col_bits[COLS_PER_SLICE][table_in_i];

  generate
    for (gi = 0; gi < CHAIN_SLICES - 1; gi++) begin : g_chain
      assign chain_out[gi] = chain_tbl_r[gi][chain_in_i[TABLE_INPUTS-1:0]];
    end
  endgenerate
  // Last chain table decodes the top four inputs into an enable for the result
  assign chain_out[CHAIN_SLICES-1] = chain_tbl_r[CHAIN_SLICES-1][chain_in_i[CHAIN_INPUTS-1:TABLE_INPUTS]];

  always_comb begin
    four_input_table_o  = 1'b0;
    five_input_table_o  = 1'b0;
    eight_input_table_o = 1'b0;
    if (mode_r == MODE_LOGIC) begin
      four_input_table_o  = t0;
      five_input_table_o  = table_sel5_i ? t1 : t0;
      // Inputs 7:6 pick among four low tables, gated by the top table: five slices in all
      eight_input_table_o = chain_out[CHAIN_SLICES-1]
                            ? chain_out[chain_in_i[CHAIN_INPUTS-1 -: 2]]
                            : 1'b0;
    end
  end

  // ************************************************************
  // Ripple mode: adders, comparator, carry chain
  // ************************************************************
  logic [ARITH_WIDTH:0]   arith_sum;
  logic [ARITH_WIDTH-1:0] b_eff;
  logic                   do_sub;
  logic [ARITH_WIDTH-1:0] gen_bits, prop_bits;

  always_comb begin
    do_sub = 1'b0;
    case (func_r)
      RIP_SUB:    do_sub = 1'b1;
      RIP_ADDSUB: do_sub = !add_nsub_i;
      default:    do_sub = 1'b0;
    endcase
    // Multiplier cell adds B only when the partial product bit is set
    if (func_r == RIP_MULT) begin
      b_eff = mult_bit_i ? op_b_i : COUNT_ZERO;
    end else begin
      b_eff = do_sub ? ~op_b_i : op_b_i;
    end
    arith_sum = {1'b0, op_a_i} + {1'b0, b_eff} + {{ARITH_WIDTH{1'b0}}, carry_i};
    gen_bits  = op_a_i & b_eff;
    prop_bits = op_a_i ^ b_eff;
  end

  always_comb begin
    sum_o        = COUNT_ZERO;
    carry_o      = 1'b0;
    carry_gen_o  = 1'b0;
    carry_prop_o = 1'b0;
    if (mode_r == MODE_RIPPLE) begin
      sum_o   = arith_sum[ARITH_WIDTH-1:0];
      carry_o = arith_sum[ARITH_WIDTH];
      if (fast_r) begin
        // Group generate/propagate over the two bits
        carry_gen_o  = gen_bits[1] | (prop_bits[1] & gen_bits[0]);
        carry_prop_o = &prop_bits;
      end
    end
  end

  // Comparator works on raw operands regardless of function
  always_comb begin
    a_ge_b_o = 1'b0;
    a_ne_b_o = 1'b0;
    a_le_b_o = 1'b0;
    if (mode_r == MODE_RIPPLE) begin
      a_ge_b_o = (op_a_i >= op_b_i);
      a_ne_b_o = (op_a_i != op_b_i);
      a_le_b_o = (op_a_i <= op_b_i);
    end
  end

  // ************************************************************
  // Ripple mode: counters
  // ************************************************************
  logic [ARITH_WIDTH-1:0] count_r, count_nxt;
  logic                   started_r, started_nxt;
  logic                   clr_now;

  // Clear acts in the same cycle it is seen, so it is not held off by enable
  assign clr_now = (func_r == RIP_UDCNT_CLR) && count_clr_i;

  always_comb begin
    count_nxt   = count_r;
    started_nxt = started_r | cfg_done_i;
    if (!started_r) begin
      count_nxt = init_r;
    end else if (mode_r == MODE_RIPPLE) begin
      case (func_r)
        RIP_UPCNT: begin
          if (count_en_i) count_nxt = count_r + COUNT_ONE;
        end
        RIP_DNCNT: begin
          if (count_en_i) count_nxt = count_r - COUNT_ONE;
        end
        RIP_UDCNT_CLR: begin
          // Clear also empties the stored count so it stays cleared after release
          if (count_clr_i) begin
            count_nxt = COUNT_ZERO;
          end else if (count_en_i) begin
            count_nxt = count_up_i ? count_r + COUNT_ONE : count_r - COUNT_ONE;
          end
        end
        RIP_UDCNT_LOAD: begin
          if (count_load_i) begin
            count_nxt = preload_i;
          end else if (count_en_i) begin
            count_nxt = count_up_i ? count_r + COUNT_ONE : count_r - COUNT_ONE;
          end
        end
        default: count_nxt = count_r;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      count_r   <= COUNT_ZERO;
      started_r <= 1'b0;
    end else begin
      count_r   <= count_nxt;
      started_r <= started_nxt;
    end
  end

  // Clear bypasses the register without waiting for an edge
  assign count_o = clr_now ? COUNT_ZERO : count_r;

endmodule
`default_nettype wire

/* sim/neighbour_slice.sv */
/*
  Neighbour slice model: the lower slice of a ripple chain feeding carry in.
  Assumes the bench drives its operands on the fabric clock.
*/
`timescale 1ns/1ps
`default_nettype none
module neighbour_slice (
  input  wire logic [1:0] nb_a_i,
  input  wire logic [1:0] nb_b_i,
  output logic            carry_o
);
  // ********
  // Carry hand-off
  // ********
  // Combinational, like one hop of a real carry chain
  assign carry_o = (nb_a_i + nb_b_i) > 3;
endmodule
`default_nettype wire

/* sim/logic_slice_modes_checker.sv */
/*
  Port-level properties of the logic slice.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module logic_slice_modes_checker
  import slice_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       cfg_we_i,
  input wire logic [1:0] cfg_mode_i,
  input wire logic [2:0] cfg_func_i,
  input wire logic       cfg_fast_carry_i,
  input wire logic       cfg_done_i,
  input wire logic       table_sel5_i,
  input wire logic [1:0] op_a_i,
  input wire logic [1:0] op_b_i,
  input wire logic       carry_i,
  input wire logic       count_clr_i,
  input wire logic       count_load_i,
  input wire logic [1:0] preload_i,
  input wire logic [3:0] ram_addr_i,
  input wire logic [3:0] ram_wdata_i,
  input wire logic       ram_we_i,
  input wire logic       four_input_table_o,
  input wire logic       five_input_table_o,
  input wire logic [1:0] sum_o,
  input wire logic       carry_o,
  input wire logic       carry_gen_o,
  input wire logic       carry_prop_o,
  input wire logic [1:0] count_o,
  input wire logic       a_ge_b_o,
  input wire logic       a_ne_b_o,
  input wire logic       a_le_b_o,
  input wire logic [3:0] ram_rdata_o,
  input wire logic [1:0] mode_o
);
  // ********
  // Shadow of the config latch
  // ********
  logic [2:0] func_r, func_nxt;
  logic       fast_r, fast_nxt;
  logic       rip;
  // Function is not a port, so track it as the latch does
  always_comb begin
    func_nxt = func_r;
    fast_nxt = fast_r;
    if (reset_i) begin
      func_nxt = 3'h0;
      fast_nxt = 1'b0;
    end else if (!cfg_done_i) begin
      func_nxt = cfg_func_i;
      fast_nxt = cfg_fast_carry_i;
    end
  end
  always_ff @(posedge clk_i) begin
    func_r <= func_nxt;
    fast_r <= fast_nxt;
  end
  assign rip = (mode_o == MODE_RIPPLE);
  // ********
  // Properties
  // ********
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);
  property p_latch;
    !cfg_done_i |=> mode_o == $past(cfg_mode_i);
  endproperty
  property p_freeze;
    cfg_done_i |=> $stable(mode_o);
  endproperty
  property p_five;
    mode_o == MODE_LOGIC && !table_sel5_i |-> five_input_table_o == four_input_table_o;
  endproperty
  property p_add;
    rip && func_r == RIP_ADD |-> {carry_o, sum_o} == op_a_i + op_b_i + carry_i;
  endproperty
  property p_cmp;
    rip |-> a_ge_b_o == (op_a_i >= op_b_i) && a_ne_b_o == (op_a_i != op_b_i) && a_le_b_o == (op_a_i <= op_b_i);
  endproperty
  property p_gp;
    rip && fast_r && func_r == RIP_ADD |-> carry_gen_o == (op_a_i + op_b_i > 3) && carry_prop_o == (op_a_i == ~op_b_i);
  endproperty
  property p_clr;
    rip && func_r == RIP_UDCNT_CLR && count_clr_i |-> count_o == 2'h0;
  endproperty
  property p_load;
    rip && func_r == RIP_UDCNT_LOAD && count_load_i && cfg_done_i && $past(cfg_done_i) |=> count_o == $past(preload_i);
  endproperty
  property p_ram;
    mode_o == MODE_RAM && cfg_done_i && ram_we_i && !cfg_we_i
      |=> ram_addr_i != $past(ram_addr_i) || ram_rdata_o == $past(ram_wdata_i);
  endproperty
  a_latch: assert property (p_latch) else $error("mode not latched");
  a_freeze: assert property (p_freeze) else $error("mode moved in user mode");
  a_five: assert property (p_five) else $error("five-input low half wrong");
  a_add: assert property (p_add) else $error("add result wrong");
  a_cmp: assert property (p_cmp) else $error("compare flags wrong");
  a_gp: assert property (p_gp) else $error("generate or propagate wrong");
  a_clr: assert property (p_clr) else $error("clear did not zero count");
  a_load: assert property (p_load) else $error("preload not taken");
  a_ram: assert property (p_ram) else $error("RAM write not read back");
  c_ram: cover property (mode_o == MODE_RAM && ram_we_i);
  c_clr: cover property (rip && func_r == RIP_UDCNT_CLR && count_clr_i);
  c_gp: cover property (rip && fast_r);
endmodule
bind logic_slice_modes logic_slice_modes_checker u_logic_slice_modes_checker (.*);
`default_nettype wire

/* sim/logic_slice_modes_bench.sv */
/*
  Bench for the logic slice: ripple rows in a loop, then hand tests.
  Assumes the checker is bound in and the neighbour model drives carry_i.
*/
`timescale 1ns/1ps
`default_nettype none
module logic_slice_modes_bench
  import slice_pkg::*;
;
  logic        clk_i, reset_i, cfg_we_i, cfg_fast_carry_i, cfg_done_i, table_sel5_i, carry_i, add_nsub_i;
  logic        count_en_i, count_up_i, count_clr_i, count_load_i, mult_bit_i, ram_we_i;
  logic [1:0]  cfg_mode_i, cfg_reg_init_i, op_a_i, op_b_i, preload_i, nb_a, nb_b, sum_o, count_o, mode_o;
  logic [2:0]  cfg_sel_i, cfg_func_i;
  logic [3:0]  table_in_i, ram_addr_i, ram_wdata_i, ram_rdata_o;
  logic [7:0]  chain_in_i;
  logic [15:0] cfg_data_i;
  logic        four_input_table_o, five_input_table_o, eight_input_table_o, carry_o, carry_gen_o, carry_prop_o;
  logic        a_ge_b_o, a_ne_b_o, a_le_b_o;
  int          fails, compares, i;
  typedef struct packed {logic [2:0] f; logic [1:0] a, b; logic c, add; logic [2:0] res;} row_type;
  // Result is carry then sum; subtracts take carry in high as no borrow; add also drives the multiplier bit
  row_type rows [8] = '{'{RIP_ADD, 2'h3, 2'h2, 1'b1, 1'b0, 3'h6}, '{RIP_ADD, 2'h1, 2'h1, 1'b0, 1'b0, 3'h2},
    '{RIP_SUB, 2'h1, 2'h2, 1'b1, 1'b0, 3'h3}, '{RIP_SUB, 2'h3, 2'h1, 1'b1, 1'b0, 3'h2},
    '{RIP_ADDSUB, 2'h2, 2'h1, 1'b0, 1'b1, 3'h3}, '{RIP_ADDSUB, 2'h2, 2'h3, 1'b1, 1'b0, 3'h3},
    '{RIP_MULT, 2'h3, 2'h2, 1'b0, 1'b1, 3'h5}, '{RIP_MULT, 2'h3, 2'h2, 1'b0, 1'b0, 3'h3}};
  localparam logic [15:0] T0 = 16'hA5C3;
  localparam logic [15:0] T1 = 16'h0F0F;
  // Chain input code in the low byte, expected output on top
  localparam logic [8:0] E8 [4] = '{9'h143, 9'h042, 9'h003, 9'h1C5};
  logic_slice_modes u_logic_slice_modes (.*);
  neighbour_slice u_neighbour_slice (.nb_a_i(nb_a), .nb_b_i(nb_b), .carry_o(carry_i));
  // 100 MHz clock
  always #5 clk_i = ~clk_i;
  // ********
  // Tasks
  // ********
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic prog(input logic [2:0] s, input logic [15:0] d);
    @(posedge clk_i);
    cfg_we_i <= 1'b1;
    cfg_sel_i <= s;
    cfg_data_i <= d;
    @(posedge clk_i);
    cfg_we_i <= 1'b0;
  endtask
  // Reset clears the counter, so each setup starts from the power-up value
  task automatic setup(input logic [1:0] m, input logic [2:0] f, input logic fc, input logic [1:0] v);
    @(posedge clk_i);
    reset_i <= 1'b1;
    cfg_done_i <= 1'b0;
    cfg_mode_i <= m;
    cfg_func_i <= f;
    cfg_fast_carry_i <= fc;
    cfg_reg_init_i <= v;
    @(posedge clk_i);
    reset_i <= 1'b0;
    @(posedge clk_i);
    cfg_done_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1 chk("mode", m, mode_o);
    chk("init", v, count_o);
  endtask
  // Hang guard: the run needs well under 1000 cycles
  initial begin
    #20000;
    fails++;
    complete_run;
  end
  // ********
  // Main sequence
  // ********
  initial begin
    clk_i = 1'b0;
    {cfg_we_i, cfg_fast_carry_i, cfg_done_i, table_sel5_i, add_nsub_i, count_en_i, count_up_i, count_clr_i} = 0;
    {count_load_i, mult_bit_i, ram_we_i, cfg_mode_i, cfg_reg_init_i, op_a_i, op_b_i, preload_i, nb_a, nb_b} = 0;
    {cfg_sel_i, cfg_func_i, table_in_i, ram_addr_i, ram_wdata_i, chain_in_i, cfg_data_i} = 0;
    reset_i = 1'b1;
    repeat (6) @(posedge clk_i);
    reset_i <= 1'b0;
    #1 chk("rst_mode", 2'h0, mode_o);
    chk("rst_count", 2'h0, count_o);
    for (i = 0; i < 8; i++) begin
      setup(MODE_RIPPLE, rows[i].f, 1'b0, 2'h0);
      op_a_i <= rows[i].a;
      op_b_i <= rows[i].b;
      nb_a <= {2{rows[i].c}};
      nb_b <= {1'b0, rows[i].c};
      add_nsub_i <= rows[i].add;
      mult_bit_i <= rows[i].add;
      @(negedge clk_i);
      chk("sum", rows[i].res[1:0], sum_o);
      if (rows[i].f == RIP_ADD || rows[i].f == RIP_MULT) chk("carry", rows[i].res[2], carry_o);
      chk("ge", rows[i].a >= rows[i].b, a_ge_b_o);
      chk("ne", rows[i].a != rows[i].b, a_ne_b_o);
      chk("le", rows[i].a <= rows[i].b, a_le_b_o);
    end
    // Tables: two local, four chained, one gate
    prog(3'h0, T0);
    prog(3'h1, T1);
    for (i = 2; i < 7; i++) prog(i[2:0], i < 6 ? 16'h0001 << i : 16'hF0F0);
    setup(MODE_LOGIC, 3'h0, 1'b0, 2'h0);
    for (i = 0; i < 16; i++) begin
      table_in_i <= i[3:0];
      table_sel5_i <= i[0];
      @(negedge clk_i);
      chk("four", T0[i], four_input_table_o);
      chk("five", i[0] ? T1[i] : T0[i], five_input_table_o);
      @(posedge clk_i);
    end
    for (i = 0; i < 4; i++) begin
      chain_in_i <= E8[i][7:0];
      @(negedge clk_i);
      chk("eight", E8[i][8], eight_input_table_o);
      @(posedge clk_i);
    end
    // Fast carry on the two boundary cases
    setup(MODE_RIPPLE, RIP_ADD, 1'b1, 2'h0);
    nb_a <= 2'h0;
    op_a_i <= 2'h2;
    op_b_i <= 2'h2;
    #1 chk("gen", 1'b1, carry_gen_o);
    chk("prop", 1'b0, carry_prop_o);
    op_a_i <= 2'h1;
    #1 chk("gen", 1'b0, carry_gen_o);
    chk("prop", 1'b1, carry_prop_o);
    // Counters: wrap, underflow, clear, preload with enable and up also high
    setup(MODE_RIPPLE, RIP_UPCNT, 1'b0, 2'h3);
    count_en_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    count_en_i <= 1'b0;
    #1 chk("up", 2'h1, count_o);
    setup(MODE_RIPPLE, RIP_DNCNT, 1'b0, 2'h0);
    count_en_i <= 1'b1;
    @(posedge clk_i);
    count_en_i <= 1'b0;
    #1 chk("down", 2'h3, count_o);
    setup(MODE_RIPPLE, RIP_UDCNT_CLR, 1'b0, 2'h2);
    count_en_i <= 1'b1;
    @(posedge clk_i);
    count_en_i <= 1'b0;
    #1 chk("updown", 2'h1, count_o);
    count_clr_i <= 1'b1;
    #1 chk("clr", 2'h0, count_o);
    @(posedge clk_i);
    count_clr_i <= 1'b0;
    #1 chk("cleared", 2'h0, count_o);
    setup(MODE_RIPPLE, RIP_UDCNT_LOAD, 1'b0, 2'h1);
    {preload_i, count_load_i, count_en_i, count_up_i} <= 5'h17;
    @(posedge clk_i);
    {count_load_i, count_en_i} <= 2'h0;
    #1 chk("load", 2'h2, count_o);
    // RAM: configured contents, back-to-back writes, then read-only refusal
    prog(3'h0, 16'h8001);
    setup(MODE_RAM, 3'h0, 1'b0, 2'h0);
    ram_addr_i <= 4'hF;
    #1 chk("init", 1'b1, ram_rdata_o[0]);
    ram_addr_i <= 4'h1;
    #1 chk("init", 1'b0, ram_rdata_o[0]);
    @(posedge clk_i);
    {ram_we_i, ram_addr_i, ram_wdata_i} <= 9'h13A;
    @(posedge clk_i);
    {ram_addr_i, ram_wdata_i} <= 8'h45;
    @(posedge clk_i);
    {ram_we_i, ram_addr_i} <= 5'h03;
    #1 chk("ram3", 4'hA, ram_rdata_o);
    ram_addr_i <= 4'h4;
    #1 chk("ram4", 4'h5, ram_rdata_o);
    setup(MODE_ROM, 3'h0, 1'b0, 2'h0);
    {ram_we_i, ram_addr_i, ram_wdata_i} <= 9'h130;
    @(posedge clk_i);
    ram_we_i <= 1'b0;
    #1 chk("rom", 4'hA, ram_rdata_o);
    complete_run;
  end
endmodule
`default_nettype wire
